/* File: hdl/sfr_cfg.svh */
// Opcodes, phase boundaries and sizes of the serial register readout.
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

// Opcodes taken on the serial input.
`define SFR_OP_OTP 8'h4b
`define SFR_OP_SR1 8'h05
`define SFR_OP_SR2 8'h35
`define SFR_OP_SR3 8'h15
`define SFR_OP_ISR 8'h65

// Rising-edge indices, counted from zero at the first opcode clock.
`define SFR_CMD_END      6'h07
`define SFR_ISR_ADDR_END 6'h0f
`define SFR_OTP_ADDR_END 6'h1f
`define SFR_DSR_DATA_AT  6'h08
`define SFR_ISR_DATA_AT  6'h18
`define SFR_OTP_DATA_AT  6'h28
`define SFR_CNT_MAX      6'h3f

// Status register index range and the byte given for empty slots.
`define SFR_SR_FIRST   8'h01
`define SFR_SR_LAST    8'h05
`define SFR_UNDEF_BYTE 8'hff

// Output byte buffer shape.
`define SFR_FIFO_W 8
`define SFR_FIFO_D 16

// Synchronised pin levels while the link is idle.
`define SFR_LINK_IDLE 3'b100

`endif

/* File: hdl/sfr_pkg.sv */
// Types shared by the serial register readout.
package sfr_pkg;

   // Pin levels of the serial link as sampled by mclk.
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
   } sfr_link_t;

   // Live status registers, index 0 holds status register 1.
   typedef logic [4:0][7:0] sfr_stat_t;

   // Operation decoded from the opcode byte.
   typedef enum logic [1:0] {
      SFR_OP_NONE = 2'b00,
      SFR_OP_OTP  = 2'b01,
      SFR_OP_DSR  = 2'b10,
      SFR_OP_ISR  = 2'b11
   } sfr_op_t;

endpackage

/* File: hdl/sfr_readout.sv */
// Byte FIFO and the serial command readout for OTP and status registers.
`timescale 1ns/1ps
`include "sfr_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Byte FIFO with valid and ready on both sides and a synchronous clear.
module sfr_fifo #(
   parameter int W = `SFR_FIFO_W,
   parameter int D = `SFR_FIFO_D
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         clear,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0]  wr_reg;
   logic [AW:0]  rd_reg;

   // Full when pointers differ only in the wrap bit.
   assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) &&
                        (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
   assign out_valid = (wr_reg != rd_reg);
   assign out_data  = mem[rd_reg[AW-1:0]];

   // Storage is written without reset.
   always_ff @(posedge mclk) begin
      if (in_valid && in_ready) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

   // Occupancy pointers; a clear empties the buffer at the end of a frame.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else if (clear) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule // sfr_fifo

////////////////////////////////////////////////////////////////////////////
// Contract
// - OTP and indirect reads are single-bit wide
// - OTP read opcode 4Bh, MSB first
// - 24-bit address, only bits 8:0 used
// - OTP bytes out MSB first while selected
// - OTP read crosses register boundaries
// - 05h, 35h, 15h read status 1-3
// - Direct read repeats live byte endlessly
// - Deselect ends direct read, output released
// - Indirect read: 65h, address, dummy, data
// - Addresses 01h-05h map to status 1-5
// - Address increments after every status byte
// - First indirect data bit on clock 24
// - Addresses 6-255 give undefined data, advance
// - Indirect address wraps FFh to 00h
// - Deselect ends indirect read, output released
// - Bits 8:7 pick register, 6:0 byte
module sfr_readout (
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire sfr_pkg::sfr_link_t  link,
   output logic                     so_out,
   output logic                     so_oe_n,
   input  wire sfr_pkg::sfr_stat_t  status,
   input  wire logic                otp_we,
   input  wire logic [8:0]          otp_waddr,
   input  wire logic [7:0]          otp_wdata
);
   import sfr_pkg::*;

   logic [7:0] otp_mem [512];
   sfr_link_t  s1_reg;
   sfr_link_t  s2_reg;
   logic       sck_prev_reg;
   logic [5:0] cnt_reg;
   logic [7:0] sh_reg;
   logic [7:0] sh_next;
   logic [23:0] addr_reg;
   sfr_op_t    op_reg;
   sfr_op_t    op_now;
   logic       data_reg;
   logic [8:0] fa_reg;
   logic [7:0] osh_reg;
   logic [2:0] bidx_reg;
   logic       so_reg;
   logic       oe_n_reg;
   logic       active;
   logic       rise;
   logic       fall;
   logic       push;
   logic       pop;
   logic [7:0] rd_byte;
   logic       f_in_ready;
   logic       f_out_valid;
   logic [7:0] f_out_data;
   logic [7:0] out_byte;

   // Opcode to operation.
   function automatic sfr_op_t op_decode(input logic [7:0] opc);
      unique case (opc)
         `SFR_OP_OTP: op_decode = SFR_OP_OTP;
         `SFR_OP_SR1, `SFR_OP_SR2, `SFR_OP_SR3: op_decode = SFR_OP_DSR;
         `SFR_OP_ISR: op_decode = SFR_OP_ISR;
         default: op_decode = SFR_OP_NONE;
      endcase
   endfunction

   // Status register index of a direct read opcode.
   function automatic logic [8:0] dsr_index(input logic [7:0] opc);
      unique case (opc)
         `SFR_OP_SR2: dsr_index = 9'h002;
         `SFR_OP_SR3: dsr_index = 9'h003;
         default:     dsr_index = 9'h001;
      endcase
   endfunction

   // Rising-edge index on which the first data bit is sampled.
   function automatic logic [5:0] data_at(input sfr_op_t op);
      unique case (op)
         SFR_OP_OTP: data_at = `SFR_OTP_DATA_AT;
         SFR_OP_ISR: data_at = `SFR_ISR_DATA_AT;
         SFR_OP_DSR: data_at = `SFR_DSR_DATA_AT;
         SFR_OP_NONE: data_at = `SFR_CNT_MAX;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and clock history; stage one feeds only stage two.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s1_reg       <= `SFR_LINK_IDLE;
         s2_reg       <= `SFR_LINK_IDLE;
         sck_prev_reg <= 1'b0; // Idle level, so no false edge.
      end else begin
         s1_reg       <= link;
         s2_reg       <= s1_reg;
         sck_prev_reg <= s2_reg.sck;
      end
   end

   assign active  = !s2_reg.cs_n;
   assign rise    = active && s2_reg.sck && !sck_prev_reg;
   assign fall    = active && !s2_reg.sck && sck_prev_reg;
   assign sh_next = {sh_reg[6:0], s2_reg.si};
   assign op_now  = (cnt_reg == `SFR_CMD_END) ? op_decode(sh_next) : op_reg;

   ////////////////////////////////////////////////////////////////////////
   // Clock counter and input shifters, MSB first on rising edges.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cnt_reg  <= '0;
         sh_reg   <= '0;
         addr_reg <= '0;
      end else if (!active) begin
         cnt_reg  <= '0;
      end else if (rise) begin
         if (cnt_reg != `SFR_CNT_MAX) begin
            cnt_reg <= cnt_reg + 6'h01;
         end
         sh_reg   <= sh_next;
         addr_reg <= {addr_reg[22:0], s2_reg.si};
      end
   end

   // Operation register, loaded after the eighth clock.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         op_reg <= SFR_OP_NONE;
      end else if (!active) begin
         op_reg <= SFR_OP_NONE;
      end else if (rise && cnt_reg == `SFR_CMD_END) begin
         op_reg <= op_decode(sh_next);
      end
   end

   // Data phase flag; the address and dummy clocks of OTP and indirect reads precede it.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         data_reg <= 1'b0;
      end else if (!active) begin
         data_reg <= 1'b0;
      end else if (rise && op_now != SFR_OP_NONE &&
                   cnt_reg + 6'h01 == data_at(op_now)) begin
         data_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // OTP array, loaded from the array side.
   always_ff @(posedge mclk) begin
      if (otp_we) begin
         otp_mem[otp_waddr] <= otp_wdata;
      end
   end

   // Byte at the fetch address.
   always_comb begin
      rd_byte = `SFR_UNDEF_BYTE;
      if (op_reg == SFR_OP_OTP) begin
         rd_byte = otp_mem[fa_reg];
      end else if (fa_reg[7:0] >= `SFR_SR_FIRST &&
                   fa_reg[7:0] <= `SFR_SR_LAST) begin
         rd_byte = status[fa_reg[2:0] - 3'h1];
      end
   end

   // A direct read bypasses the buffer; a prefetched byte would be stale.
   assign push = data_reg && active && f_in_ready && op_reg != SFR_OP_DSR;

   // Fetch address: a direct read's index from the opcode, held; otherwise loaded from the address field, then advanced.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fa_reg <= '0;
      end else if (rise && cnt_reg == `SFR_CMD_END) begin
         fa_reg <= dsr_index(sh_next);
      end else if (rise && op_reg == SFR_OP_ISR &&
                   cnt_reg == `SFR_ISR_ADDR_END) begin
         fa_reg <= {1'b0, sh_next};
      end else if (rise && op_reg == SFR_OP_OTP &&
                   cnt_reg == `SFR_OTP_ADDR_END) begin
         fa_reg <= {addr_reg[7:0], s2_reg.si};
      end else if (push && op_reg == SFR_OP_OTP) begin
         fa_reg <= fa_reg + 9'h001;
      end else if (push && op_reg == SFR_OP_ISR) begin
         fa_reg <= {1'b0, fa_reg[7:0] + 8'h01};
      end
   end

   sfr_fifo #(
      .W (`SFR_FIFO_W),
      .D (`SFR_FIFO_D)
   ) u_fifo (
      .mclk      (mclk),
      .reset     (reset),
      .clear     (!active),
      .in_valid  (push),
      .in_ready  (f_in_ready),
      .in_data   (rd_byte),
      .out_valid (f_out_valid),
      .out_ready (pop),
      .out_data  (f_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bytes start on a falling edge; a direct read takes its live register.
   assign pop      = fall && data_reg && bidx_reg == 3'h0 && f_out_valid;
   assign out_byte = (op_reg == SFR_OP_DSR) ? rd_byte :
                     f_out_valid ? f_out_data : `SFR_UNDEF_BYTE;

   // Output shifter, MSB first, on falling edges; enable low in data.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         osh_reg  <= '0;
         bidx_reg <= '0;
         so_reg   <= 1'b0;
         oe_n_reg <= 1'b1;
      end else if (!active) begin
         bidx_reg <= '0;
         oe_n_reg <= 1'b1;
      end else if (fall && data_reg) begin
         bidx_reg <= bidx_reg + 3'h1;
         oe_n_reg <= 1'b0;
         if (bidx_reg == 3'h0) begin
            so_reg  <= out_byte[7];
            osh_reg <= {out_byte[6:0], 1'b0};
         end else begin
            so_reg  <= osh_reg[7];
            osh_reg <= {osh_reg[6:0], 1'b0};
         end
      end
   end

   assign so_out  = so_reg;
   assign so_oe_n = oe_n_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the decoder, the fetch address and the output pin.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_release;
      !active |=> so_oe_n;
   endproperty
   a_release: assert property (p_release)
      else $error("Output still driven after deselect.");
   property p_quiet;
      !data_reg |-> ##1 (so_oe_n || data_reg);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("Output driven outside the data phase.");
   property p_dsr_decode;
      rise && cnt_reg == `SFR_CMD_END && sh_next == `SFR_OP_SR2
      |=> op_reg == SFR_OP_DSR && fa_reg == 9'h002 && data_reg;
   endproperty
   a_dsr_decode: assert property (p_dsr_decode)
      else $error("Direct read opcode not decoded.");
   property p_dsr_hold;
      data_reg && op_reg == SFR_OP_DSR |=> $stable(fa_reg);
   endproperty
   a_dsr_hold: assert property (p_dsr_hold)
      else $error("Direct read moved its register.");
   property p_dsr_live;
      fall && data_reg && bidx_reg == 3'h0 && op_reg == SFR_OP_DSR
      |=> so_out == $past(rd_byte[7]);
   endproperty
   a_dsr_live: assert property (p_dsr_live)
      else $error("Direct read byte not taken live.");
   property p_otp_addr;
      rise && op_reg == SFR_OP_OTP && cnt_reg == `SFR_OTP_ADDR_END
      |=> fa_reg == addr_reg[8:0];
   endproperty
   a_otp_addr: assert property (p_otp_addr)
      else $error("OTP start address not taken from bits 8:0.");
   property p_otp_step;
      push && op_reg == SFR_OP_OTP |=> fa_reg == $past(fa_reg) + 9'h001;
   endproperty
   a_otp_step: assert property (p_otp_step)
      else $error("OTP address did not advance.");
   property p_isr_wrap;
      push && op_reg == SFR_OP_ISR && fa_reg == 9'h0ff |=> fa_reg == 9'h000;
   endproperty
   a_isr_wrap: assert property (p_isr_wrap)
      else $error("Indirect address did not wrap.");
   property p_isr_map;
      push && op_reg == SFR_OP_ISR && fa_reg == 9'h003
      |-> rd_byte == status[2];
   endproperty
   a_isr_map: assert property (p_isr_map)
      else $error("Indirect address 03h not status register 3.");
   property p_isr_start;
      $rose(data_reg) && op_reg == SFR_OP_ISR |-> cnt_reg == 6'h18;
   endproperty
   a_isr_start: assert property (p_isr_start)
      else $error("Indirect data phase started on wrong clock.");
   property p_msb;
      pop |=> so_out == $past(f_out_data[7]);
   endproperty
   a_msb: assert property (p_msb)
      else $error("Byte not sent most significant bit first.");

   c_otp: cover property (push && op_reg == SFR_OP_OTP && fa_reg == 9'h080);
   c_dsr: cover property (fall && op_reg == SFR_OP_DSR && cnt_reg == 6'h20);
   c_isr: cover property (push && op_reg == SFR_OP_ISR && fa_reg == 9'h0ff);
   c_cut: cover property (data_reg && bidx_reg == 3'h3 ##1 !active);
endmodule // sfr_readout

/* File: bench/sfr_host.sv */
// Serial host model that frames commands and collects the returned bytes.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module sfr_host (
   input  wire logic          mclk,
   output sfr_pkg::sfr_link_t link,
   input  wire logic          so_out,
   input  wire logic          so_oe_n,
   output logic               rx_stb,
   output logic [7:0]         rx_byte,
   output int                 oe_err
);
   import sfr_pkg::*;

   logic busy;

   // Start deselected with the clock low and nothing received.
   initial begin
      link = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      busy = 1'b0;
      rx_stb = 1'b0;
      rx_byte = 8'h00;
      oe_err = 0;
   end

   // The input line toggles on every mclk fall between frames, so it never holds a value.
   always @(negedge mclk) begin
      if (!busy) begin
         link.si <= ~link.si;
      end
   end

   // One frame: header bits, then data clocks; the clock idles low (mode 0).
   // Low phase is 5 mclk so the shifted bit has settled before sampling.
   task automatic frame(input logic [47:0] hdr, input int nh, input int nd,
                        input bit quiet);
      int i;
      logic [7:0] sh;
      sh = 8'h00;
      busy = 1'b1;
      @(negedge mclk);
      link.cs_n = 1'b0;
      for (i = 0; i < nh * 8 + nd; i++) begin
         link.sck = 1'b0;
         link.si = (i < nh * 8) ? hdr[47 - i] : ~link.si;
         repeat (5) @(negedge mclk);
         if (so_oe_n !== 1'(quiet || i < nh * 8)) begin
            oe_err++;
         end
         // A released line shows the inverse of its last value.
         sh = {sh[6:0], so_oe_n ? ~so_out : so_out};
         link.sck = 1'b1;
         rx_byte = sh;
         rx_stb = !quiet && i >= nh * 8 && (i - nh * 8) % 8 == 7;
         @(negedge mclk);
         rx_stb = 1'b0;
         repeat (2) @(negedge mclk);
      end
      link.sck = 1'b0;
      @(negedge mclk);
      link.cs_n = 1'b1;
      repeat (5) @(negedge mclk);
      busy = 1'b0;
   endtask

endmodule // sfr_host

/* File: bench/testbench.sv */
// Self-checking bench for the serial OTP and status register readout.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module testbench;
   import sfr_pkg::*;

   logic       mclk, reset, so_out, so_oe_n, otp_we, rx_stb;
   sfr_link_t  link;
   sfr_stat_t  status;
   logic [8:0] otp_waddr;
   logic [7:0] otp_wdata, rx_byte;
   logic [7:0] otp_img [512];
   logic [7:0] dop [3] = '{8'h05, 8'h35, 8'h15};
   logic [7:0] expq [$];
   int         error_cnt, n_tests, oe_err, seed, i, k, a;

   sfr_readout u_dut (
      .mclk      (mclk),
      .reset     (reset),
      .link      (link),
      .so_out    (so_out),
      .so_oe_n   (so_oe_n),
      .status    (status),
      .otp_we    (otp_we),
      .otp_waddr (otp_waddr),
      .otp_wdata (otp_wdata)
   );

   sfr_host u_host (
      .mclk    (mclk),
      .link    (link),
      .so_out  (so_out),
      .so_oe_n (so_oe_n),
      .rx_stb  (rx_stb),
      .rx_byte (rx_byte),
      .oe_err  (oe_err)
   );

   // System clock at 50 MHz.
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("errors %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // A frame, then the output must be released and never driven early.
   task automatic run(input logic [47:0] hdr, input int nh, input int nd,
                      input bit quiet);
      u_host.frame(hdr, nh, nd, quiet);
      check({7'h00, so_oe_n}, 8'h01, "release after deselect");
      check(8'(oe_err), 8'h00, "output enable phase");
   endtask

   // Fresh random contents for all five status registers.
   task automatic new_status;
      for (int j = 0; j < 5; j++) status[j] = 8'($random(seed));
   endtask

   function automatic logic [7:0] isr_exp(input logic [7:0] ad);
      return (ad >= 8'h01 && ad <= 8'h05) ? status[3'(ad - 8'h01)] : 8'hff;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Every received byte is compared with the oldest expectation.
   always @(posedge mclk) begin
      if (rx_stb) begin
         if (expq.size() == 0) begin
            error_cnt++;
            $display("mismatch at %0t: unexpected byte %h", $time, rx_byte);
         end else begin
            check(rx_byte, expq.pop_front(), "read byte");
         end
      end
   end

   // Cuts a hang short well beyond the expected run time.
   initial begin
      #1500000;
      error_cnt++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test;
   end

   // Main sequence.
   initial begin
      seed = 32'h101ceea6;
      reset = 1'b1;
      status = '0;
      otp_we = 1'b0;
      otp_waddr = 9'h000;
      otp_wdata = 8'h00;
      error_cnt = 0;
      n_tests = 0;
      repeat (4) @(negedge mclk);
      reset = 1'b0;
      repeat (3) @(negedge mclk);
      check({7'h00, so_oe_n}, 8'h01, "idle enable");
      for (i = 0; i < 512; i++) begin
         otp_img[i] = 8'($random(seed));
         otp_we = 1'b1;
         otp_waddr = 9'(i);
         otp_wdata = otp_img[i];
         @(negedge mclk);
      end
      otp_we = 1'b0;
      new_status;
      // Whole OTP area from byte 128, across the 256 and 384 boundaries and the wrap.
      a = 128;
      for (i = 0; i < 512; i++) expq.push_back(otp_img[(a + i) % 512]);
      run({8'h4b, 15'($random(seed)), 9'(a), 8'($random(seed)), 8'h00},
          5, 4096, 1'b0);
      // Direct reads: live value re-read for every repeated byte.
      for (k = 0; k < 3; k++) begin
         fork
            run({dop[k], 40'h0}, 1, 32, 1'b0);
            for (i = 0; i < 4; i++) begin
               expq.push_back(status[k]);
               @(posedge rx_stb);
               @(negedge mclk);
               status[k] = 8'($random(seed));
            end
         join
      end
      // Indirect reads from 01h and across the FFh to 00h wrap.
      for (k = 0; k < 2; k++) begin
         a = k ? 8'hfd : 8'h01;
         new_status;
         for (i = 0; i < 7 + 3 * k; i++) expq.push_back(isr_exp(8'(a + i)));
         run({8'h65, 8'(a), 8'($random(seed)), 24'h0}, 3,
             8 * (7 + 3 * k), 1'b0);
      end
      // Deselect in mid-byte for each read kind, then an unknown opcode.
      expq.push_back(status[0]);
      run({8'h05, 40'h0}, 1, 11, 1'b0);
      run({8'h65, 8'h02, 8'h00, 24'h0}, 3, 5, 1'b0);
      a = int'(9'($random(seed)));
      for (i = 0; i < 2; i++) expq.push_back(otp_img[(a + i) % 512]);
      run({8'h4b, 15'h0, 9'(a), 16'h0}, 5, 19, 1'b0);
      run({8'h9f, 40'h0}, 1, 16, 1'b1);
      check(8'(expq.size()), 8'h00, "bytes outstanding");
      stop_test;
   end

endmodule // testbench
